// ==== twm_master.sv ====
// two-wire bus master with AHB-Lite register access
// Functional notes
// - enable, start and flag write launch transfer
// - start only on free bus, report 0x08
// - after address+read, flag set, 0x38/0x40/0x48
// - received byte readable when flag set
// - last received byte answered with NACK
// - stop written with flag ends transfer
// - repeated start reports 0x10, bus kept
// - 0x30, no start/stop: send next byte
// - 0x30 with start: repeated start, data kept
// - 0x30 with stop: stop, stop bit cleared
// - 0x30 with both: stop then start
// - 0x38 without start: release bus, unaddressed
// - 0x38 with start: wait free, then start
// - lose arbitration when driven one reads zero
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module twm_master
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [twm_pkg::AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [twm_pkg::DW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [twm_pkg::DW-1:0] hrdata,
  input wire logic link_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  import twm_pkg::*;

  // core domain
  logic wr_q, rp_q;
  logic [7:0] wa_q;
  logic en_q, sta_q, sto_q, ack_q, flag_q;
  logic [1:0] pre_q;
  logic [7:0] dat_q, stat_q;
  logic cmd_tgl_q, done_p_q, done_s;
  // link domain
  twm_lst_t st_q;
  logic [1:0] ph_q;
  logic [7:0] cnt_q;
  logic own_q, busy_q, addr_q, rd_q, rx_q, pend_q, cmd_ack_q;
  logic sda_p_q, scl_p_q;
  logic [8:0] sh_q, rs_q;
  logic [3:0] bit_q;
  logic [7:0] stat_l_q, rx_l_q;
  logic flag_l_q, done_tgl_q;
  logic [2:0] lin_s;

  wire take = hsel && hready && htrans[1];
  wire wr_ctrl = wr_q && wa_q == ADDR_CTRL;
  wire wr_stat = wr_q && wa_q == ADDR_STAT;
  wire wr_data = wr_q && wa_q == ADDR_DATA;
  wire launch = wr_ctrl && hwdata[B_FLAG] && hwdata[B_EN];
  wire flag_clr = wr_ctrl && hwdata[B_FLAG];
  wire done_ev = done_s ^ done_p_q;
  wire [7:0] stat_m = stat_l_q & STAT_MASK;
  wire rx_res = stat_m == ST_DR_ACK || stat_m == ST_DR_NACK;
  wire [7:0] ctrl_rd = {flag_q, ack_q, sta_q, sto_q, 1'b0, en_q, 2'b00};
  wire [7:0] stat_rd = {stat_q[7:3], 1'b0, pre_q};
  wire [7:0] rd_byte = wa_q == ADDR_CTRL ? ctrl_rd :
    wa_q == ADDR_STAT ? stat_rd :
    wa_q == ADDR_DATA ? dat_q : 8'h00;

  // reads take one wait state so a preceding write is seen
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q <= 1'b0;
      rp_q <= 1'b0;
      wa_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end
    else
    begin
      wr_q <= take && hwrite;
      rp_q <= take && !hwrite;
      hreadyout <= !(take && !hwrite);
      hresp <= 1'b0;
      if (take)
        wa_q <= haddr[7:0];
      if (rp_q)
        hrdata <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en_q <= 1'b0;
      sta_q <= 1'b0;
      sto_q <= 1'b0;
      ack_q <= 1'b0;
      flag_q <= 1'b0;
      pre_q <= 2'b00;
      dat_q <= RST_DATA;
      stat_q <= ST_IDLE;
      cmd_tgl_q <= 1'b0;
      done_p_q <= 1'b0;
    end
    else
    begin
      done_p_q <= done_s;
      if (wr_ctrl)
      begin
        en_q <= hwdata[B_EN];
        sta_q <= hwdata[B_STA];
        ack_q <= hwdata[B_ACK];
      end
      if (wr_ctrl)
        sto_q <= hwdata[B_STO];
      else if (done_ev)
        sto_q <= 1'b0;
      // hardware set wins over a same-cycle clear
      if (done_ev && flag_l_q)
        flag_q <= 1'b1;
      else if (flag_clr)
        flag_q <= 1'b0;
      if (done_ev && rx_res)
        dat_q <= rx_l_q;
      else if (wr_data)
        dat_q <= hwdata[7:0];
      if (done_ev)
        stat_q <= stat_l_q;
      if (wr_stat)
        pre_q <= hwdata[1:0];
      if (launch)
        cmd_tgl_q <= ~cmd_tgl_q;
    end
  end

  twm_sync #(.W(1), .RV(1'b0)) u_done_sync
  (
    .clk(core_clk),
    .nrst(nrst),
    .d(done_tgl_q),
    .q(done_s)
  );

  twm_sync #(.W(3), .RV(3'b110)) u_link_sync
  (
    .clk(link_clk),
    .nrst(nrst),
    .d({scl_i, sda_i, cmd_tgl_q}),
    .q(lin_s)
  );

  // link domain; command fields are stable while the toggle settles
  wire scl_s = lin_s[2];
  wire sda_s = lin_s[1];
  wire cmd_s = lin_s[0];
  wire tick = cnt_q == 8'h00;
  wire waiting = st_q == L_IDLE || st_q == L_HOLD;
  wire go = cmd_s != cmd_ack_q && waiting;
  wire rx_nxt = rd_q && !addr_q;
  wire lost = st_q == L_BIT && ph_q == 2'd2 && tick && !rx_q &&
    bit_q < LAST_BIT && sda_oe_n && !sda_s;
  wire nack = rs_q[0];
  wire [7:0] adr_st = rd_q ? (nack ? ST_AR_NACK : ST_AR_ACK) :
    (nack ? ST_AW_NACK : ST_AW_ACK);
  wire [7:0] dat_st = rx_q ? (nack ? ST_DR_NACK : ST_DR_ACK) :
    (nack ? ST_DW_NACK : ST_DW_ACK);
  wire [7:0] byte_st = addr_q ? adr_st : dat_st;
  wire start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;

  task automatic report(input logic [7:0] code, input logic f);
    stat_l_q <= code;
    flag_l_q <= f;
    done_tgl_q <= ~done_tgl_q;
  endtask

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
    end
    else
    begin
      sda_p_q <= sda_s;
      scl_p_q <= scl_s;
      if (start_c)
        busy_q <= 1'b1;
      else if (stop_c)
        busy_q <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= L_IDLE;
      ph_q <= 2'd0;
      cnt_q <= QTR_CNT;
      own_q <= 1'b0;
      addr_q <= 1'b0;
      rd_q <= 1'b0;
      rx_q <= 1'b0;
      pend_q <= 1'b0;
      cmd_ack_q <= 1'b0;
      sh_q <= 9'h1FF;
      rs_q <= 9'h000;
      bit_q <= 4'h0;
      stat_l_q <= ST_IDLE;
      rx_l_q <= 8'h00;
      flag_l_q <= 1'b0;
      done_tgl_q <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      cnt_q <= (tick || waiting) ? QTR_CNT : cnt_q - 8'h01;
      case (st_q)
        L_IDLE, L_HOLD:
        begin
          // the clock stays low in hold until software answers
          if (go)
          begin
            cmd_ack_q <= cmd_s;
            ph_q <= 2'd0;
            if (sto_q && own_q)
            begin
              st_q <= L_STOP;
              pend_q <= sta_q;
            end
            else if (sta_q)
              st_q <= L_START;
            else if (own_q)
            begin
              st_q <= L_BIT;
              bit_q <= 4'h0;
              rx_q <= rx_nxt;
              sh_q <= rx_nxt ? {8'hFF, !ack_q} : {dat_q, 1'b1};
              if (addr_q)
                rd_q <= dat_q[0];
            end
            else
              report(ST_IDLE, 1'b0);
          end
        end
        L_START:
        begin
          case (ph_q)
            2'd0:
            begin
              sda_oe_n <= 1'b1;
              if (tick && (own_q || !busy_q))
                ph_q <= 2'd1;
            end
            2'd1:
            begin
              scl_oe_n <= 1'b1;
              if (tick && scl_s)
                ph_q <= 2'd2;
            end
            2'd2:
            begin
              sda_oe_n <= 1'b0;
              if (tick)
                ph_q <= 2'd3;
            end
            default:
            begin
              scl_oe_n <= 1'b0;
              if (tick)
              begin
                st_q <= L_HOLD;
                addr_q <= 1'b1;
                own_q <= 1'b1;
                report(own_q ? ST_RSTART : ST_START, 1'b1);
              end
            end
          endcase
        end
        L_STOP:
        begin
          case (ph_q)
            2'd0:
            begin
              sda_oe_n <= 1'b0;
              if (tick)
                ph_q <= 2'd1;
            end
            2'd1:
            begin
              scl_oe_n <= 1'b1;
              if (tick && scl_s)
                ph_q <= 2'd2;
            end
            2'd2:
            begin
              sda_oe_n <= 1'b1;
              if (tick)
                ph_q <= 2'd3;
            end
            default:
            begin
              if (tick)
              begin
                own_q <= 1'b0;
                ph_q <= 2'd0;
                pend_q <= 1'b0;
                if (pend_q)
                  st_q <= L_START;
                else
                begin
                  st_q <= L_IDLE;
                  report(ST_IDLE, 1'b0);
                end
              end
            end
          endcase
        end
        L_BIT:
        begin
          case (ph_q)
            2'd0:
            begin
              sda_oe_n <= sh_q[8];
              if (tick)
                ph_q <= 2'd1;
            end
            2'd1:
            begin
              scl_oe_n <= 1'b1;
              if (tick && scl_s)
                ph_q <= 2'd2;
            end
            2'd2:
            begin
              if (tick)
              begin
                rs_q <= {rs_q[7:0], sda_s};
                ph_q <= 2'd3;
                if (lost)
                begin
                  sda_oe_n <= 1'b1;
                  scl_oe_n <= 1'b1;
                  own_q <= 1'b0;
                  st_q <= L_IDLE;
                  report(ST_ARB, 1'b1);
                end
              end
            end
            default:
            begin
              scl_oe_n <= 1'b0;
              if (tick)
              begin
                sh_q <= {sh_q[7:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                ph_q <= 2'd0;
                if (bit_q == LAST_BIT)
                begin
                  sda_oe_n <= 1'b1;
                  addr_q <= 1'b0;
                  st_q <= L_HOLD;
                  rx_l_q <= rs_q[8:1];
                  report(byte_st, 1'b1);
                end
              end
            end
          endcase
        end
        default:
          st_q <= L_IDLE;
      endcase
    end
  end

  // checks, core domain
  property p_launch;
    @(posedge core_clk) disable iff (!nrst)
    launch && !done_ev |=> !flag_q && cmd_tgl_q != $past(cmd_tgl_q);
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch did not clear flag and toggle");

  property p_flag_set;
    @(posedge core_clk) disable iff (!nrst)
    done_ev && flag_l_q |=> flag_q && stat_q == $past(stat_l_q);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("step done flag not set with status");

  property p_rx_load;
    @(posedge core_clk) disable iff (!nrst)
    done_ev && rx_res |=> dat_q == $past(rx_l_q) && flag_q;
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("received byte not in data register");

  property p_sto_clr;
    @(posedge core_clk) disable iff (!nrst)
    done_ev && !wr_ctrl |=> !sto_q;
  endproperty
  a_sto_clr: assert property (p_sto_clr)
    else $error("stop request not cleared");

  property p_mask;
    @(posedge core_clk) disable iff (!nrst)
    done_ev |=> (stat_rd & STAT_MASK) == $past(stat_l_q);
  endproperty
  a_mask: assert property (p_mask)
    else $error("status code corrupted by prescaler bits");

  // checks, link domain
  property p_free;
    @(posedge link_clk) disable iff (!nrst)
    st_q == L_START && ph_q == 2'd0 && !own_q && busy_q
      |=> st_q == L_START && ph_q == 2'd0;
  endproperty
  a_free: assert property (p_free)
    else $error("start issued on busy bus");

  property p_hold;
    @(posedge link_clk) disable iff (!nrst)
    st_q == L_HOLD |-> !scl_oe_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("clock not held low while flag pending");

  property p_arb;
    @(posedge link_clk) disable iff (!nrst)
    lost |=> st_q == L_IDLE && scl_oe_n && sda_oe_n
      && stat_l_q == ST_ARB && !own_q;
  endproperty
  a_arb: assert property (p_arb)
    else $error("arbitration loss not handled");

  property p_nack;
    @(posedge link_clk) disable iff (!nrst)
    st_q == L_BIT && rx_q && bit_q == LAST_BIT && ph_q == 2'd1
      |-> sda_oe_n == !ack_q;
  endproperty
  a_nack: assert property (p_nack)
    else $error("wrong acknowledge level on received byte");

  property p_rstart;
    @(posedge link_clk) disable iff (!nrst)
    st_q == L_START && ph_q == 2'd3 && tick && own_q
      |=> stat_l_q == ST_RSTART && st_q == L_HOLD && own_q;
  endproperty
  a_rstart: assert property (p_rstart)
    else $error("repeated start status wrong");

  property p_stop;
    @(posedge link_clk) disable iff (!nrst)
    st_q == L_STOP && ph_q == 2'd3 |-> sda_oe_n && scl_oe_n;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop condition lines not released");

  c_rx: cover property (@(posedge core_clk) done_ev && rx_res);
  c_arb: cover property (@(posedge link_clk) lost);
  c_stop_start: cover property (@(posedge link_clk)
    st_q == L_STOP && ph_q == 2'd3 && tick && pend_q);
endmodule

// ==== twm_pkg.sv ====
// constants and types for the two-wire master controller
package twm_pkg;
  localparam int DW = 32;
  localparam int AW = 32;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  // control register fields
  localparam int B_FLAG = 7;
  localparam int B_ACK = 6;
  localparam int B_STA = 5;
  localparam int B_STO = 4;
  localparam int B_EN = 2;
  // status codes, prescaler bits masked off
  localparam logic [7:0] STAT_MASK = 8'hF8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_DW_ACK = 8'h28;
  localparam logic [7:0] ST_DW_NACK = 8'h30;
  localparam logic [7:0] ST_ARB = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_DR_ACK = 8'h50;
  localparam logic [7:0] ST_DR_NACK = 8'h58;
  localparam logic [7:0] ST_IDLE = 8'hF8;
  localparam logic [7:0] RST_DATA = 8'hFF;
  // bus clock quarter period, on the link clock
  localparam int SCL_QTR_NS = 2500;
  localparam int LINK_PER_PS = 12000;
  localparam int QTR_CYC = (SCL_QTR_NS * 1000 + LINK_PER_PS - 1)
    / LINK_PER_PS;
  localparam logic [7:0] QTR_CNT = 8'(QTR_CYC - 1);
  localparam logic [3:0] LAST_BIT = 4'h8;
  typedef enum logic [2:0] {L_IDLE, L_HOLD, L_START, L_STOP, L_BIT}
    twm_lst_t;
endpackage

// ==== twm_sync.sv ====
// two-flop synchroniser for signals entering a clock domain
`timescale 1ns/1ps
module twm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RV = '0
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import twm_pkg::*;
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= RV;
      q <= RV;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ==== twm_i2c_slave.sv ====
// behavioural bus slave plus a competing master for the two-wire bench
`timescale 1ns/1ps
module twm_i2c_slave #(
  parameter logic [6:0] SLV_ADDR = 7'h2A
)
(
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  input wire logic contend,
  output logic scl_pull_n,
  output logic sda_pull_n,
  output logic [7:0] got_byte,
  output logic got_nack
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'hC3;
  logic act = 0, first = 0, sel = 0, rd = 0, drv = 0;
  int cnt = 0;
  initial
  begin
    scl_pull_n = 1'b1;
    got_byte = 8'h00;
    got_nack = 1'b0;
  end
  // other master holding data low wins any one bit
  assign sda_pull_n = ~(drv | contend);
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      act = 1;
      first = 1;
      sel = 0;
      drv = 0;
      cnt = -1;
      tx = 8'hC3;
    end
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      act = 0;
      drv = 0;
    end
  always @(posedge scl)
    if (act)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else if (sel && rd && !first)
      begin
        got_nack = sda;
        // released after a nack so the master can end the transfer
        if (sda)
          sel = 0;
      end
    end
  always @(negedge scl)
    if (act)
    begin
      cnt = cnt + 1;
      if (cnt == 9)
      begin
        cnt = 0;
        if (!first && rd)
          tx = ~tx;
        first = 0;
      end
      if (cnt == 8 && first)
      begin
        sel = (sh[7:1] == SLV_ADDR);
        rd = sh[0];
      end
      // written data bytes are refused so the master sees a nack
      if (cnt == 8 && !first && !rd)
        got_byte = sh;
      drv = (cnt == 8 && first && sel) ||
        (sel && rd && !first && cnt < 8 && !tx[7 - cnt]);
    end
  // slow mode stretches every low phase of the bus clock
  // long enough to outlast the master's own low time
  always @(negedge scl)
    if (slow)
    begin
      scl_pull_n = 1'b0;
      #9000;
      scl_pull_n = 1'b1;
    end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the two-wire master controller
`timescale 1ns/1ps
module tb_top;
  import twm_pkg::*;
  localparam logic [6:0] SLV = 7'h2A;
  logic core_clk = 0, link_clk = 0, nrst = 0;
  logic hsel = 0, hwrite = 0, slow = 0, contend = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  wire logic hready;
  logic scl_oe_n, sda_oe_n, scl_pull_n, sda_pull_n, got_nack;
  logic scl_o, sda_o, hresp;
  logic [7:0] got_byte;
  int errors = 0, checks_done = 0;
  // a driven line shows the driven level, a released one the pull-up
  wire logic scl = (scl_oe_n | scl_o) & scl_pull_n;
  wire logic sda = (sda_oe_n | sda_o) & sda_pull_n;
  always #4 core_clk = ~core_clk;
  // link rising edges never meet core rising edges
  always #6 link_clk = ~link_clk;
  twm_master dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  twm_i2c_slave #(.SLV_ADDR(SLV)) slv (.scl(scl), .sda(sda),
    .slow(slow), .contend(contend), .scl_pull_n(scl_pull_n),
    .sda_pull_n(sda_pull_n), .got_byte(got_byte), .got_nack(got_nack));
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] stv(input logic [7:0] s);
    // prescaler bits stay at 3 once t_regs has written them
    return {24'h0, s | 8'h03};
  endfunction
  // ready is sampled from the settled value before the edge
  task automatic hs();
    int n;
    logic r;
    n = 0;
    do
    begin
      @(negedge core_clk);
      r = hready;
      rd = hrdata;
      @(posedge core_clk);
      n++;
    end
    while (r !== 1'b1 && n < 50);
    if (r !== 1'b1)
    begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hs();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    hs();
  endtask
  task automatic wait_reg(input logic [7:0] a, input logic [7:0] m);
    int n;
    n = 0;
    do
    begin
      bus(a, 1'b0, 8'h00);
      n++;
    end
    while ((rd[7:0] & m) !== m && n < 9000);
    if ((rd[7:0] & m) !== m)
    begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic step(input logic [7:0] c);
    bus(ADDR_CTRL, 1'b1, c);
    wait_reg(ADDR_CTRL, 8'h80);
    bus(ADDR_STAT, 1'b0, 8'h00);
  endtask
  task automatic t_regs();
    bus(ADDR_CTRL, 1'b0, 8'h00);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    bus(ADDR_STAT, 1'b0, 8'h00);
    chk(rd, {24'h0, ST_IDLE});
    bus(ADDR_DATA, 1'b0, 8'h00);
    chk(rd, {24'h0, RST_DATA});
    bus(8'h0C, 1'b1, 8'h55);
    bus(8'h0C, 1'b0, 8'h00);
    chk(rd, 32'h0);
    bus(ADDR_STAT, 1'b1, 8'h03);
    bus(ADDR_STAT, 1'b0, 8'h00);
    chk(rd, stv(ST_IDLE));
  endtask
  task automatic t_receive();
    step(8'hA4);
    chk(rd, stv(ST_START));
    repeat (300) @(posedge core_clk);
    chk({31'h0, scl_oe_n}, 32'h0);
    bus(ADDR_DATA, 1'b1, {SLV, 1'b1});
    step(8'h84);
    chk(rd, stv(ST_AR_ACK));
    step(8'hC4);
    chk(rd, stv(ST_DR_ACK));
    chk({31'h0, got_nack}, 32'h0);
    bus(ADDR_DATA, 1'b0, 8'h00);
    chk(rd, 32'hC3);
    step(8'h84);
    chk(rd, stv(ST_DR_NACK));
    chk({31'h0, got_nack}, 32'h1);
    bus(ADDR_DATA, 1'b0, 8'h00);
    chk(rd, 32'h3C);
    step(8'hA4);
    chk(rd, stv(ST_RSTART));
    chk({31'h0, scl_oe_n}, 32'h0);
  endtask
  task automatic t_write();
    bus(ADDR_DATA, 1'b1, {SLV, 1'b0});
    step(8'h84);
    chk(rd, stv(ST_AW_ACK));
    bus(ADDR_DATA, 1'b1, 8'h5A);
    step(8'h84);
    chk(rd, stv(ST_DW_NACK));
    slow <= 1'b1;
    bus(ADDR_DATA, 1'b1, 8'hA5);
    step(8'h84);
    chk(rd, stv(ST_DW_NACK));
    chk({24'h0, got_byte}, 32'hA5);
    slow <= 1'b0;
    step(8'hA4);
    chk(rd, stv(ST_RSTART));
    bus(ADDR_DATA, 1'b0, 8'h00);
    chk(rd, 32'hA5);
    step(8'hB4);
    chk(rd, stv(ST_START));
    bus(ADDR_CTRL, 1'b0, 8'h00);
    chk(rd & 32'h10, 32'h0);
    bus(ADDR_CTRL, 1'b1, 8'h94);
    wait_reg(ADDR_STAT, 8'hF8);
    bus(ADDR_CTRL, 1'b0, 8'h00);
    chk(rd & 32'h10, 32'h0);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
  endtask
  task automatic t_arb(input logic restart);
    step(8'hA4);
    bus(ADDR_DATA, 1'b1, 8'hFF);
    contend <= 1'b1;
    step(8'h84);
    chk(rd, stv(ST_ARB));
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    if (restart)
    begin
      bus(ADDR_CTRL, 1'b1, 8'hA4);
      // bus stays busy while the rival holds data low
      repeat (2000) @(posedge core_clk);
      bus(ADDR_CTRL, 1'b0, 8'h00);
      chk(rd & 32'h80, 32'h0);
      contend <= 1'b0;
      wait_reg(ADDR_CTRL, 8'h80);
      bus(ADDR_STAT, 1'b0, 8'h00);
      chk(rd, stv(ST_START));
      bus(ADDR_CTRL, 1'b1, 8'h94);
      wait_reg(ADDR_STAT, 8'hF8);
    end
    else
    begin
      bus(ADDR_CTRL, 1'b1, 8'h84);
      wait_reg(ADDR_STAT, 8'hF8);
      chk(rd, stv(ST_IDLE));
      bus(ADDR_CTRL, 1'b0, 8'h00);
      chk(rd & 32'h80, 32'h0);
      contend <= 1'b0;
    end
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_receive();
    t_write();
    t_arb(1'b0);
    t_arb(1'b1);
    print_verdict();
  end
endmodule
